/* File: hdl/modem_cfg_params.svh */
// constants for the modem configuration A control block
// assumes a 32-bit classic wishbone bus with byte addresses
`ifndef MODEM_CFG_PARAMS_SVH
`define MODEM_CFG_PARAMS_SVH

`define MCA_OFFSET 32'h00000000
`define ANT_CTRL_OFFSET 32'h00000100
`define STATUS_OFFSET 32'h00000104
`define ADDR_MASK 32'hfffffffc

`define MCA_RESET 8'h00
`define ANT_CTRL_RESET 2'h0

`define CTRL_DUAL_BIT 0
`define CTRL_EXT_HDR_BIT 1

`define STAT_ANT_BIT 0
`define STAT_CNT_BIT 1
`define STAT_COUNT_LSB 16

`define LEN_W 16

`endif

/* File: hdl/modem_cfg_pkg.sv */
// types shared by the modem configuration A control block
// assumes modem_cfg_params.svh is on the include path
package modem_cfg_pkg;

  typedef enum logic [1:0] {
    HDR_SFD_ONLY,
    HDR_SFD_CRC,
    HDR_LEN_CRC,
    HDR_FULL
  } hdr_mode_t;

  // field order is the register bit order, msb first
  typedef struct packed {
    logic ant_tx;
    logic ant_single;
    logic full_duplex;
    hdr_mode_t hdr_mode;
    logic sfd_timer;
    logic len_count;
    logic unused;
  } modem_config_a_t;

  typedef struct packed {
    logic header_dbpsk;
    logic payload_dbpsk_forced;
    logic payload_mod_free;
    logic crc16_en;
    logic length_en;
    logic full_header;
  } hdr_ctl_t;

  typedef enum logic [1:0] {
    REG_MCA,
    REG_ANT_CTRL,
    REG_STATUS,
    REG_NONE
  } reg_id_t;

  typedef enum logic {
    CNT_IDLE,
    CNT_RUN
  } cnt_state_t;

endpackage

/* File: hdl/length_counter.sv */
// receive payload length counter with restart to acquisition
// assumes sfd_end_i and rx_data_bit_i are one-cycle pulses on clk_i
`timescale 1ns/1ps
`include "modem_cfg_params.svh"
module length_counter #(
  parameter int LEN_W = `LEN_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic sfd_end_i,
  input wire logic [LEN_W-1:0] rx_len_i,
  input wire logic rx_data_bit_i,
  output logic [LEN_W-1:0] remaining_o,
  output logic counting_o,
  output logic restart_o
);
  import modem_cfg_pkg::*;

  typedef struct packed {
    cnt_state_t state;
    logic [LEN_W-1:0] count;
    logic restart;
  } cnt_st_t;

  cnt_st_t st;
  cnt_st_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.restart = 1'b0;
    if (sfd_end_i)
    begin
      if (rx_len_i == '0)
      begin
        next_st.restart = 1'b1;
        next_st.state = CNT_IDLE;
        next_st.count = '0;
      end
      else if (enable_i)
      begin
        next_st.state = CNT_RUN;
        next_st.count = rx_len_i;
      end
    end
    else
    begin
      case (st.state)
        CNT_IDLE:
        begin
          next_st.count = '0;
        end
        CNT_RUN:
        begin
          if (!enable_i)
          begin
            next_st.state = CNT_IDLE;
            next_st.count = '0;
          end
          else if (rx_data_bit_i)
          begin
            next_st.count = st.count - 1'b1;
            if (st.count == LEN_W'(1))
            begin
              next_st.state = CNT_IDLE;
              next_st.restart = 1'b1;
            end
          end
        end
        default:
        begin
          next_st.state = CNT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign remaining_o = st.count;
  assign counting_o = (st.state == CNT_RUN);
  assign restart_o = st.restart;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence last_bit_s;
    st.state == CNT_RUN && st.count == LEN_W'(1) && rx_data_bit_i && enable_i && !sfd_end_i;
  endsequence
  sequence restart_pulse_s;
    restart_o && !counting_o ##1 !restart_o;
  endsequence

  count_load_a: assert property (
    sfd_end_i && enable_i && rx_len_i != '0 |=> counting_o && remaining_o == $past(rx_len_i))
    else $error("length count did not load");
  count_done_a: assert property (
    last_bit_s |=> restart_pulse_s)
    else $error("no single restart pulse at end of length count");
  zero_len_a: assert property (
    sfd_end_i && rx_len_i == '0 |=> restart_o && !counting_o)
    else $error("zero length field did not restart receiver");
endmodule // length_counter

/* File: hdl/modem_config_antenna_header_ctrl.sv */
// modem configuration A register, antenna select, header mode and length count
// assumes a classic wishbone master on clk_i and a receiver supplying sfd and length
// Functional notes
// - bit 7 picks the transmit antenna, one meaning antenna A.
// - single antenna drives the antenna output from bit 6; dual ignores it.
// - full duplex with dual antennas uses bit 7 while transmitting, else the receiver's antenna.
// - half duplex with dual antennas always follows the receiver's chosen antenna.
// - header mode 0 sfd only, 1 crc, 2 length and crc, 3 full.
// - preamble and header always dbpsk; mode 0 payload dbpsk too.
// - modes 1 to 3 let payload modulation be chosen freely.
// - header mode is ignored when the header is generated externally.
// - length count bit with mode 2 or 3 counts received data bits.
// - completed length count returns the receiver to acquisition.
// - zero length field restarts the receiver at sfd end, always.
// - registers sit on word addresses, the two low address bits unused.
`timescale 1ns/1ps
`include "modem_cfg_params.svh"
module modem_config_antenna_header_ctrl #(
  parameter int LEN_W = `LEN_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic transmit_path_enable_i,
  input wire logic rx_antenna_choice_i,
  input wire logic sfd_end_i,
  input wire logic [LEN_W-1:0] rx_len_i,
  input wire logic rx_data_bit_i,
  output logic antenna_select_out_o,
  output modem_cfg_pkg::hdr_mode_t header_mode_o,
  output modem_cfg_pkg::hdr_ctl_t hdr_ctl_o,
  output logic rx_restart_o
);
  import modem_cfg_pkg::*;

  typedef struct packed {
    modem_config_a_t cfg;
    logic dual_ant;
    logic ext_hdr;
    logic ack;
    logic [31:0] rdata;
    logic transmit_path_enable_meta;
    logic transmit_path_enable_sync;
    logic ant;
    hdr_mode_t mode;
    hdr_ctl_t ctl;
  } ctrl_st_t;

  ctrl_st_t st;
  ctrl_st_t next_st;
  logic cnt_enable;
  logic [LEN_W-1:0] remaining;
  logic counting;
  logic bus_req;
  reg_id_t rd_id;
  reg_id_t wr_id;
  localparam logic [1:0] ANT_CTRL_INIT = `ANT_CTRL_RESET;

  // word decode, low two address bits never looked at
  function automatic reg_id_t reg_sel(input logic [31:0] adr);
    logic [31:0] word;
    word = adr & `ADDR_MASK;
    if (word == `MCA_OFFSET)
      reg_sel = REG_MCA;
    else if (word == `ANT_CTRL_OFFSET)
      reg_sel = REG_ANT_CTRL;
    else if (word == `STATUS_OFFSET)
      reg_sel = REG_STATUS;
    else
      reg_sel = REG_NONE;
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign rd_id = reg_sel(wb_adr_i);
  assign wr_id = reg_sel(wb_adr_i);

  always_comb
  begin
    next_st = st;
    next_st.transmit_path_enable_meta = transmit_path_enable_i;
    next_st.transmit_path_enable_sync = st.transmit_path_enable_meta;
    next_st.ack = bus_req && !st.ack;

    // read data is captured when the request is first seen and stands with ack
    if (bus_req && !st.ack)
    begin
      next_st.rdata = '0;
      if (rd_id == REG_MCA)
        next_st.rdata[7:0] = st.cfg;
      else if (rd_id == REG_ANT_CTRL)
      begin
        next_st.rdata[`CTRL_DUAL_BIT] = st.dual_ant;
        next_st.rdata[`CTRL_EXT_HDR_BIT] = st.ext_hdr;
      end
      else if (rd_id == REG_STATUS)
      begin
        next_st.rdata[`STAT_ANT_BIT] = st.ant;
        next_st.rdata[`STAT_CNT_BIT] = counting;
        next_st.rdata[`STAT_COUNT_LSB +: LEN_W] = remaining;
      end
    end

    // writes take effect on the edge that carries ack
    if (bus_req && wb_we_i && st.ack && wb_sel_i[0])
    begin
      if (wr_id == REG_MCA)
      begin
        next_st.cfg = modem_config_a_t'(wb_dat_i[7:0]);
        next_st.cfg.unused = 1'b0;
      end
      else if (wr_id == REG_ANT_CTRL)
      begin
        next_st.dual_ant = wb_dat_i[`CTRL_DUAL_BIT];
        next_st.ext_hdr = wb_dat_i[`CTRL_EXT_HDR_BIT];
      end
    end

    // antenna select
    if (!st.dual_ant)
      next_st.ant = st.cfg.ant_single;
    else if (st.cfg.full_duplex && st.transmit_path_enable_sync)
      next_st.ant = st.cfg.ant_tx;
    else
      next_st.ant = rx_antenna_choice_i;

    // header generation controls
    next_st.mode = st.cfg.hdr_mode;
    next_st.ctl = '0;
    next_st.ctl.header_dbpsk = 1'b1;
    if (st.ext_hdr)
      next_st.ctl.payload_mod_free = 1'b1;
    else
    begin
      case (st.cfg.hdr_mode)
        HDR_SFD_ONLY:
        begin
          next_st.ctl.payload_dbpsk_forced = 1'b1;
        end
        HDR_SFD_CRC:
        begin
          next_st.ctl.payload_mod_free = 1'b1;
          next_st.ctl.crc16_en = 1'b1;
        end
        HDR_LEN_CRC:
        begin
          next_st.ctl.payload_mod_free = 1'b1;
          next_st.ctl.crc16_en = 1'b1;
          next_st.ctl.length_en = 1'b1;
        end
        HDR_FULL:
        begin
          next_st.ctl.payload_mod_free = 1'b1;
          next_st.ctl.crc16_en = 1'b1;
          next_st.ctl.length_en = 1'b1;
          next_st.ctl.full_header = 1'b1;
        end
        default:
        begin
          next_st.ctl.payload_dbpsk_forced = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.cfg <= modem_config_a_t'(`MCA_RESET);
      st.dual_ant <= ANT_CTRL_INIT[`CTRL_DUAL_BIT];
      st.ext_hdr <= ANT_CTRL_INIT[`CTRL_EXT_HDR_BIT];
    end
    else
      st <= next_st;
  end

  // length counting only with an internal header carrying a length field
  assign cnt_enable = st.cfg.len_count && !st.ext_hdr
    && (st.cfg.hdr_mode == HDR_LEN_CRC || st.cfg.hdr_mode == HDR_FULL);

  length_counter #(
    .LEN_W(LEN_W)
  ) u_len (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(cnt_enable),
    .sfd_end_i(sfd_end_i),
    .rx_len_i(rx_len_i),
    .rx_data_bit_i(rx_data_bit_i),
    .remaining_o(remaining),
    .counting_o(counting),
    .restart_o(rx_restart_o)
  );

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign antenna_select_out_o = st.ant;
  assign header_mode_o = st.mode;
  assign hdr_ctl_o = st.ctl;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence mca_read_req_s;
    bus_req && !st.ack && !wb_we_i && rd_id == REG_MCA;
  endsequence

  sequence mca_write_s;
    bus_req && wb_we_i && st.ack && wb_sel_i[0] && wr_id == REG_MCA;
  endsequence

  ant_tx_a: assert property (
    st.dual_ant && st.cfg.full_duplex && st.transmit_path_enable_sync
    |=> antenna_select_out_o == $past(st.cfg.ant_tx))
    else $error("transmit antenna bit not on antenna output");

  ant_single_a: assert property (
    !st.dual_ant |=> antenna_select_out_o == $past(st.cfg.ant_single))
    else $error("single antenna bit not on antenna output");

  ant_full_rx_a: assert property (
    st.dual_ant && st.cfg.full_duplex && !st.transmit_path_enable_sync
    |=> antenna_select_out_o == $past(rx_antenna_choice_i))
    else $error("full duplex receive did not follow receiver antenna");

  ant_half_a: assert property (
    st.dual_ant && !st.cfg.full_duplex
    |=> antenna_select_out_o == $past(rx_antenna_choice_i))
    else $error("half duplex did not follow receiver antenna");

  mode_decode_a: assert property (
    !st.ext_hdr && st.cfg.hdr_mode == HDR_LEN_CRC
    |=> hdr_ctl_o.length_en && hdr_ctl_o.crc16_en && !hdr_ctl_o.full_header
      && header_mode_o == HDR_LEN_CRC)
    else $error("header mode 2 decoded wrongly");

  dbpsk_fixed_a: assert property (
    !st.ext_hdr && st.cfg.hdr_mode == HDR_SFD_ONLY
    |=> hdr_ctl_o.payload_dbpsk_forced && hdr_ctl_o.header_dbpsk
      && !hdr_ctl_o.payload_mod_free)
    else $error("mode 0 payload not forced to dbpsk");

  free_mod_a: assert property (
    !st.ext_hdr && st.cfg.hdr_mode != HDR_SFD_ONLY
    |=> hdr_ctl_o.payload_mod_free && !hdr_ctl_o.payload_dbpsk_forced)
    else $error("payload modulation not free in modes 1 to 3");

  ext_ignore_a: assert property (
    st.ext_hdr |-> !cnt_enable ##1 (!hdr_ctl_o.crc16_en && !hdr_ctl_o.length_en
      && !hdr_ctl_o.full_header))
    else $error("header mode acted on with external header");

  count_gate_a: assert property (
    !st.cfg.len_count || st.cfg.hdr_mode == HDR_SFD_CRC |-> !cnt_enable)
    else $error("length count enabled outside modes 2 and 3");

  word_read_a: assert property (
    mca_read_req_s |=> wb_ack_o && wb_dat_o[7:0] == $past(st.cfg) && wb_dat_o[31:8] == '0)
    else $error("config register read at word address failed");

  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  unused_zero_a: assert property (
    st.cfg.unused == 1'b0)
    else $error("unused config bit stored");

  ack_answer_a: assert property (
    bus_req && !st.ack |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  cfg_write_a: assert property (
    mca_write_s |=> st.cfg == modem_config_a_t'({$past(wb_dat_i[7:1]), 1'b0}))
    else $error("config write not stored with bit 0 cleared");

  sel_drop_a: assert property (
    bus_req && wb_we_i && st.ack && !wb_sel_i[0] |=> st.cfg == $past(st.cfg))
    else $error("write without byte lane 0 changed the config");

  mode_full_a: assert property (
    !st.ext_hdr && st.cfg.hdr_mode == HDR_FULL
    |=> hdr_ctl_o.full_header && hdr_ctl_o.length_en && hdr_ctl_o.crc16_en
      && header_mode_o == HDR_FULL)
    else $error("header mode 3 decoded wrongly");

  mode_crc_a: assert property (
    !st.ext_hdr && st.cfg.hdr_mode == HDR_SFD_CRC
    |=> hdr_ctl_o.crc16_en && !hdr_ctl_o.length_en && !hdr_ctl_o.full_header)
    else $error("header mode 1 decoded wrongly");

  read_bit0_a: assert property (
    mca_read_req_s |=> !wb_dat_o[0])
    else $error("unused config bit read back as one");

  status_ant_a: assert property (
    bus_req && !st.ack && !wb_we_i && rd_id == REG_STATUS
    |=> wb_dat_o[`STAT_ANT_BIT] == $past(antenna_select_out_o))
    else $error("status read did not show the antenna output");
endmodule // modem_config_antenna_header_ctrl

/* File: tb/wb_host.sv */
// host model: classic wishbone master issuing single reads and writes
// assumes a slave that acks each request within the wait bound
`timescale 1ns/1ps
module wb_host
(
  input wire logic clk_i,
  input wire logic ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [31:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o,
  output logic hung_o
);
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 32'h0;
    dat_o = 32'h0;
    sel_o = 4'h0;
    hung_o = 1'b0;
  end

  // one request, held until the edge that samples ack high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    sel_o <= s;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 50);
    if (ack_i !== 1'b1)
      hung_o <= 1'b1;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released we_o, adr_o and dat_o lines do not keep their last value; sel_o keeps it
    we_o <= ~w;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule // wb_host

/* File: tb/modem_config_antenna_header_ctrl_tb.sv */
// self-checking bench for the modem configuration A control block
// assumes the design package, header and wb_host are compiled first
`timescale 1ns/1ps
module modem_config_antenna_header_ctrl_tb;
  import modem_cfg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, hung, ant, restart, dual, ext;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  logic tx = 1'b0;
  logic rxch = 1'b0;
  logic sfd = 1'b0;
  logic bitp = 1'b0;
  logic [15:0] len = 16'h0;
  hdr_mode_t mode;
  hdr_ctl_t hctl;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] rd_q[$];
  int rs_q[$];
  logic [7:0] cfg;
  logic ea;
  logic [5:0] eh, mask;
  logic [7:0] lc_cfg[5] = '{8'h12, 8'h1a, 8'h0a, 8'h10, 8'h00};
  logic lc_exp[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  always #20 clk_i = ~clk_i;

  wb_host host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .dat_o(wdat), .sel_o(sel), .hung_o(hung));

  modem_config_antenna_header_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .transmit_path_enable_i(tx),
    .rx_antenna_choice_i(rxch), .sfd_end_i(sfd), .rx_len_i(len), .rx_data_bit_i(bitp),
    .antenna_select_out_o(ant), .header_mode_o(mode), .hdr_ctl_o(hctl),
    .rx_restart_o(restart));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    host.xfer(1'b0, a, 32'h0, 4'hf);
  endtask

  // one frame: sfd pulse with a length, then n single-cycle data bits
  task automatic lenrun(input logic [15:0] l, input logic e);
    if (e)
      rs_q.push_back(1);
    repeat (2) @(posedge clk_i);
    sfd <= 1'b1;
    len <= l;
    @(posedge clk_i);
    sfd <= 1'b0;
    len <= ~l;
    repeat (int'(l))
    begin
      @(posedge clk_i);
      bitp <= 1'b1;
      @(posedge clk_i);
      bitp <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    chk("pending restarts", 32'h0, 32'(rs_q.size()));
  endtask

  always @(posedge hung)
  begin
    error_cnt++;
    end_of_test;
  end

  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0)
      chk("read data", rd_q.pop_front(), rdat);
    if (restart === 1'b1)
    begin
      chk("restart pulse", 32'h1, 32'(rs_q.size() != 0));
      if (rs_q.size() != 0)
        rs_q.delete(0);
    end
  end

  initial
  begin
    void'($urandom(55768));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(32'h0, 32'h0);
    host.xfer(1'b1, 32'h0, 32'hff, 4'h1);
    rd(32'h2, 32'hfe);
    host.xfer(1'b1, 32'h0, 32'h0, 4'he);
    rd(32'h0, 32'hfe);
    rd(32'h8, 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      cfg = 8'($urandom);
      dual = 1'($urandom);
      ext = 1'($urandom);
      host.xfer(1'b1, 32'h100, {30'h0, ext, dual}, 4'h1);
      host.xfer(1'b1, 32'h0, {24'h0, cfg}, 4'h1);
      @(posedge clk_i);
      tx <= 1'($urandom);
      rxch <= 1'($urandom);
      repeat (6) @(posedge clk_i);
      ea = !dual ? cfg[6] : (cfg[5] && tx) ? cfg[7] : rxch;
      chk("antenna", 32'(ea), 32'(ant));
      chk("header mode", 32'(cfg[4:3]), 32'(mode));
      eh = {1'b1, cfg[4:3] == 2'h0, cfg[4:3] != 2'h0, cfg[4:3] != 2'h0, cfg[4],
            cfg[4:3] == 2'h3};
      mask = 6'h3f;
      if (ext)
      begin
        eh = 6'h28;
        mask = 6'h2f;
      end
      chk("header control", 32'(eh), 32'(hctl & mask));
      rd(32'h0, {24'h0, cfg[7:1], 1'b0});
      rd(32'h100, {30'h0, ext, dual});
      rd(32'h104, {31'h0, ea});
    end
    host.xfer(1'b1, 32'h100, 32'h0, 4'h1);
    for (int i = 0; i < 5; i++)
    begin
      host.xfer(1'b1, 32'h0, {24'h0, lc_cfg[i]}, 4'h1);
      lenrun((i == 4) ? 16'h0 : 16'($urandom_range(8, 1)), lc_exp[i]);
    end
    repeat (3) @(posedge clk_i);
    chk("read backlog", 32'h0, 32'(rd_q.size()));
    end_of_test;
  end
endmodule // modem_config_antenna_header_ctrl_tb
